// File: hdl/ebw_map.svh
// Register offsets, field positions, reset values and timing counts of the bus wait block
`ifndef EBW_MAP_SVH
`define EBW_MAP_SVH

// Byte offsets on the register bus
`define EBW_OFS_BUS_CTRL    6'h00
`define EBW_OFS_AREA0       6'h04
`define EBW_OFS_AREA1       6'h08
`define EBW_OFS_AREA2       6'h0c
`define EBW_OFS_AREA3       6'h10

// External bus control fields
`define EBW_BIT_REQ_HOLD    23
`define EBW_BIT_RSVD        22
`define EBW_BIT_OWNER       21
`define EBW_DFW_HI          20
`define EBW_DFW_LO          16
`define EBW_A3W_HI          15
`define EBW_A3W_LO          13
`define EBW_A2W_HI          12
`define EBW_A2W_LO          10
`define EBW_A1W_HI          9
`define EBW_A1W_LO          5
`define EBW_A0W_HI          4
`define EBW_A0W_LO          0

// Area attribute fields: compare base, compare mask, DRAM type, enable
`define EBW_AAR_BASE_HI     23
`define EBW_AAR_BASE_LO     16
`define EBW_AAR_MASK_HI     15
`define EBW_AAR_MASK_LO     8
`define EBW_AAR_DRAM        1
`define EBW_AAR_EN          0

// Reset values
`define EBW_BUS_CTRL_RST    24'h1f_ffff
`define EBW_AAR_RST         24'h00_0000

// Trailing wait thresholds and counts
`define EBW_TRAIL1_MIN      5'h04
`define EBW_TRAIL2_MIN      5'h08
`define EBW_TRAIL_ONE       5'h01
`define EBW_TRAIL_TWO       5'h02

`endif

// File: hdl/ebw_pkg.sv
// Types shared by the bus wait block
package ebw_pkg;

    // External access sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_GRANT  = 3'b001,
        ST_STROBE = 3'b010,
        ST_TRAIL  = 3'b011,
        ST_DRAM   = 3'b100,
        ST_DONE   = 3'b101
    } ebw_state_type;

endpackage : ebw_pkg

// File: hdl/ebw_area_match.sv
// Address match of one attribute-defined area
`timescale 1ns/1ns
`include "ebw_map.svh"
module ebw_area_match #(
    parameter int ADDR_W = 24
) (
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [23:0]       attr,
    output logic                   hit,
    output logic                   isDram
);

    // Upper address byte compared under mask; a clear mask bit is a don't care
    wire logic [7:0] topByte = addr[ADDR_W-1 -: 8];
    wire logic [7:0] base    = attr[`EBW_AAR_BASE_HI:`EBW_AAR_BASE_LO];
    wire logic [7:0] mask    = attr[`EBW_AAR_MASK_HI:`EBW_AAR_MASK_LO];

    assign hit    = attr[`EBW_AAR_EN] && (((topByte ^ base) & mask) == 8'h00);
    assign isDram = attr[`EBW_AAR_DRAM];

endmodule : ebw_area_match

// File: hdl/ebw_down_cnt.sv
// Loadable down counter that flags its last cycle
`timescale 1ns/1ns
module ebw_down_cnt #(
    parameter int WIDTH = 5
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadVal,
    output logic                  last
);

    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    // Hold at zero once run down so a stale count never retriggers
    assign cnt_nxt = load ? loadVal : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
    assign last    = (cnt_r <= {{(WIDTH-1){1'b0}}, 1'b1});

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule : ebw_down_cnt

// File: hdl/ebw_bus_ctrl.sv
// External bus control register and SRAM wait-state sequencer
//
// Contract
// - Request hold bit keeps bus request asserted; else only while an access pends.
// - Bit 21 is read-only and reads one while this device owns the bus.
// - All other control bits read and write; reserved bit 22 resets to zero.
// - Bits 20-16 give 1..31 waits outside every attribute area; reset all ones.
// - Default-area accesses always run as SRAM cycles, never DRAM cycles.
// - Bits 15-13 give 1..7 waits for area 3 SRAM; DRAM ignores them.
// - Bits 12-10 give 1..7 waits for area 2 SRAM, reset seven; DRAM ignores.
// - Bits 9-5 give 1..31 waits for area 1 SRAM, reset 31; DRAM ignores.
// - Bits 4-0 give 1..31 waits for area 0 SRAM, reset 31; DRAM ignores.
// - Four to seven waits append one trailing wait at the access end.
// - Eight or more waits append two trailing waits at the access end.
// - Trailing waits extend hold and release only; data is sampled no later.
`timescale 1ns/1ns
// Offsets, field positions and reset values come from the shared map
`include "ebw_map.svh"
module ebw_bus_ctrl #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 24
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Register bus
    input  wire logic [5:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // Core access port
    input  wire logic              accReq,
    input  wire logic              accWrite,
    input  wire logic [ADDR_W-1:0] accAddr,
    input  wire logic [DATA_W-1:0] accWdata,
    output logic      [DATA_W-1:0] accRdata,
    output logic                   accDone,
    // Arbitration
    output logic                   busReqOut,
    input  wire logic              busGrant,
    // External SRAM pins
    output logic      [ADDR_W-1:0] extAddr,
    output logic      [DATA_W-1:0] extDataOut,
    output logic                   extDataOe,
    input  wire logic [DATA_W-1:0] extDataIn,
    output logic                   extRdN,
    output logic                   extWrN,
    // Hand-off to the dynamic memory controller
    output logic                   dramReq,
    input  wire logic              dramDone
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [23:0]              busCtrl_r;
    logic [23:0]              busCtrl_nxt;
    logic [3:0][23:0]         areaAttr_r;
    logic [3:0][23:0]         areaAttr_nxt;
    logic                     owner_r;
    logic                     ack_r;
    logic [31:0]              rdData_r;

    // Sequencer storage
    ebw_pkg::ebw_state_type   state_r;
    ebw_pkg::ebw_state_type   state_nxt;
    logic [ADDR_W-1:0]        addr_r;
    logic [DATA_W-1:0]        wdata_r;
    logic [DATA_W-1:0]        rdAcc_r;
    logic                     write_r;
    logic [1:0]               trail_r;

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    wire logic       busReq     = avs_read | avs_write;
    wire logic       selCtrl    = (avs_address == `EBW_OFS_BUS_CTRL);
    wire logic [3:0] selArea;
    wire logic       selAny     = selCtrl | (|selArea);
    wire logic       doWrite    = avs_write & ack_r;
    wire logic [31:0] byteMask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire logic [23:0] wrMask    = byteMask[23:0];
    wire logic [23:0] wrVal     = avs_writedata[23:0];

    // Address decode of the attribute registers
    assign selArea[0] = (avs_address == `EBW_OFS_AREA0);
    assign selArea[1] = (avs_address == `EBW_OFS_AREA1);
    assign selArea[2] = (avs_address == `EBW_OFS_AREA2);
    assign selArea[3] = (avs_address == `EBW_OFS_AREA3);

    // One wait cycle per access: the answer comes at the second edge
    assign avs_waitrequest = busReq & ~ack_r;
    assign avs_readdata    = rdData_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= busReq & ~ack_r;
        end
    end

    // ------------------------------------------------------------------
    // Control register write: byte lanes merge, stored owner bit never read back
    // ------------------------------------------------------------------
    wire logic [23:0] ctrlMerged = (busCtrl_r & ~wrMask) | (wrVal & wrMask);

    assign busCtrl_nxt = (doWrite && selCtrl) ? ctrlMerged : busCtrl_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busCtrl_r <= `EBW_BUS_CTRL_RST;
        end else begin
            busCtrl_r <= busCtrl_nxt;
        end
    end

    // Attribute registers share the same merge
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : gArea
            wire logic [23:0] merged = (areaAttr_r[gi] & ~wrMask) | (wrVal & wrMask);
            assign areaAttr_nxt[gi] = (doWrite && selArea[gi]) ? merged : areaAttr_r[gi];
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            areaAttr_r <= {4{`EBW_AAR_RST}};
        end else begin
            areaAttr_r <= areaAttr_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read data: owner state replaces the stored bit, unmapped reads zero
    // ------------------------------------------------------------------
    wire logic [23:0] ctrlView;
    wire logic [23:0] areaView;
    wire logic [23:0] readView;

    assign ctrlView = {busCtrl_r[`EBW_BIT_REQ_HOLD], busCtrl_r[`EBW_BIT_RSVD],
                       owner_r, busCtrl_r[`EBW_DFW_HI:0]};
    assign areaView = selArea[0] ? areaAttr_r[0] :
                      selArea[1] ? areaAttr_r[1] :
                      selArea[2] ? areaAttr_r[2] :
                      selArea[3] ? areaAttr_r[3] : 24'h00_0000;
    assign readView = selCtrl ? ctrlView : areaView;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdData_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            rdData_r <= selAny ? {8'h00, readView} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Area selection for the pending access
    // ------------------------------------------------------------------
    wire logic [3:0] areaHit;
    wire logic [3:0] areaDram;

    generate
        for (gi = 0; gi < 4; gi++) begin : gMatch
            ebw_area_match #(
                .ADDR_W (ADDR_W)
            ) uMatch (
                .addr   (addr_r),
                .attr   (areaAttr_r[gi]),
                .hit    (areaHit[gi]),
                .isDram (areaDram[gi])
            );
        end
    endgenerate

    // Lowest-index hit wins; no hit falls back to the default area
    wire logic [4:0] areaWaits;
    wire logic       selDram;

    assign areaWaits =
        areaHit[0] ? busCtrl_r[`EBW_A0W_HI:`EBW_A0W_LO] :
        areaHit[1] ? busCtrl_r[`EBW_A1W_HI:`EBW_A1W_LO] :
        areaHit[2] ? {2'b00, busCtrl_r[`EBW_A2W_HI:`EBW_A2W_LO]} :
        areaHit[3] ? {2'b00, busCtrl_r[`EBW_A3W_HI:`EBW_A3W_LO]} :
                     busCtrl_r[`EBW_DFW_HI:`EBW_DFW_LO];

    // A DRAM area skips the wait fields; the default area can never be DRAM
    assign selDram = areaHit[0] ? areaDram[0] :
                     areaHit[1] ? areaDram[1] :
                     areaHit[2] ? areaDram[2] :
                     areaHit[3] ? areaDram[3] : 1'b0;

    // A zero field is illegal; run it as one wait rather than an endless strobe
    wire logic [4:0] strobeLen = (areaWaits == 5'h00) ? 5'h01 : areaWaits;

    // Trailing waits depend on the programmed count only
    wire logic [1:0] trailSel =
        (strobeLen >= `EBW_TRAIL2_MIN) ? 2'd2 :
        (strobeLen >= `EBW_TRAIL1_MIN) ? 2'd1 :
                                         2'd0;

    // ------------------------------------------------------------------
    // Wait counter shared by the strobe and trailing phases
    // ------------------------------------------------------------------
    wire logic       cntLast;
    wire logic       loadStrobe = (state_r == ebw_pkg::ST_GRANT) && busGrant && !selDram;
    wire logic       loadTrail  = (state_r == ebw_pkg::ST_STROBE) && cntLast &&
                                  (trail_r != 2'd0);
    wire logic [4:0] loadVal    = loadTrail ? ((trail_r == 2'd2) ? `EBW_TRAIL_TWO
                                                                 : `EBW_TRAIL_ONE)
                                            : strobeLen;

    ebw_down_cnt #(
        .WIDTH   (5)
    ) uWaitCnt (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (loadStrobe | loadTrail),
        .loadVal  (loadVal),
        .last     (cntLast)
    );

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ebw_pkg::ST_IDLE: begin
                if (accReq) begin
                    state_nxt = ebw_pkg::ST_GRANT;
                end
            end
            ebw_pkg::ST_GRANT: begin
                if (busGrant) begin
                    state_nxt = selDram ? ebw_pkg::ST_DRAM : ebw_pkg::ST_STROBE;
                end
            end
            ebw_pkg::ST_STROBE: begin
                if (cntLast) begin
                    state_nxt = (trail_r != 2'd0) ? ebw_pkg::ST_TRAIL : ebw_pkg::ST_DONE;
                end
            end
            ebw_pkg::ST_TRAIL: begin
                if (cntLast) begin
                    state_nxt = ebw_pkg::ST_DONE;
                end
            end
            ebw_pkg::ST_DRAM: begin
                if (dramDone) begin
                    state_nxt = ebw_pkg::ST_DONE;
                end
            end
            ebw_pkg::ST_DONE: begin
                state_nxt = ebw_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = ebw_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ebw_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Request captured once so the pins stay stable through the trailing phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_r  <= '0;
            wdata_r <= '0;
            write_r <= 1'b0;
        end else if (state_r == ebw_pkg::ST_IDLE && accReq) begin
            addr_r  <= accAddr;
            wdata_r <= accWdata;
            write_r <= accWrite;
        end
    end

    // Trail count latched at strobe start, after the area decode settled
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trail_r <= 2'd0;
        end else if (loadStrobe) begin
            trail_r <= trailSel;
        end
    end

    // Read data taken on the last strobe cycle, before any trailing wait
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdAcc_r <= '0;
        end else if ((state_r == ebw_pkg::ST_STROBE && cntLast && !write_r) ||
                     (state_r == ebw_pkg::ST_DRAM && dramDone && !write_r)) begin
            rdAcc_r <= extDataIn;
        end
    end

    // ------------------------------------------------------------------
    // Bus ownership and request
    // ------------------------------------------------------------------
    wire logic accPending = accReq | (state_r != ebw_pkg::ST_IDLE);

    assign busReqOut = busCtrl_r[`EBW_BIT_REQ_HOLD] | accPending;

    // Master only while the arbiter grants a request we actually drive
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            owner_r <= 1'b0;
        end else begin
            owner_r <= busGrant & busReqOut;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive: strobes only in the strobe phase, data held through trail
    // ------------------------------------------------------------------
    wire logic inStrobe = (state_r == ebw_pkg::ST_STROBE);
    wire logic inTrail  = (state_r == ebw_pkg::ST_TRAIL);

    assign extAddr    = addr_r;
    assign extDataOut = wdata_r;
    assign extDataOe  = write_r & (inStrobe | inTrail);
    assign extRdN     = ~(inStrobe & ~write_r);
    assign extWrN     = ~(inStrobe & write_r);
    assign dramReq    = (state_r == ebw_pkg::ST_DRAM);

    // Answer to the core
    assign accRdata = rdAcc_r;
    assign accDone  = (state_r == ebw_pkg::ST_DONE);

endmodule : ebw_bus_ctrl

// File: test/ebw_bus_ctrl_monitor.sv
// Port-level concurrent checks of the bus wait block
`timescale 1ns/1ns
module ebw_bus_ctrl_monitor (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        accReq,
    input wire logic        accDone,
    input wire logic        busReqOut,
    input wire logic        busGrant,
    input wire logic        extDataOe,
    input wire logic        extRdN,
    input wire logic        extWrN,
    input wire logic        dramReq
);
    logic holdR;
    logic ctrlWr;
    logic ctrlRd;
    logic owned;

    // Accepted control accesses and current bus ownership
    assign ctrlWr = avs_write && !avs_waitrequest && (avs_address == 6'h00);
    assign ctrlRd = avs_read && !avs_waitrequest && (avs_address == 6'h00);
    assign owned  = busGrant && busReqOut;

    // Mirror of the hold bit, taken at the same edge the register takes it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            holdR <= 1'b0;
        end else if (ctrlWr && avs_byteenable[2]) begin
            holdR <= avs_writedata[23];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_REQ_HOLD: assert property (holdR |-> busReqOut)
        else $error("bus request low while hold is set");
    AST_REQ_ACC: assert property (accReq |-> busReqOut)
        else $error("bus request low during a pending access");
    AST_REQ_IDLE: assert property (!holdR && !accReq |-> !busReqOut)
        else $error("bus request high with nothing pending");
    AST_OWNER_SET: assert property (owned [*4] ##0 ctrlRd |-> avs_readdata[21])
        else $error("owner bit clear while owning the bus");
    AST_OWNER_CLR: assert property (!owned [*4] ##0 ctrlRd |-> !avs_readdata[21])
        else $error("owner bit set while not owning the bus");
    AST_WAIT_ONE: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest)
        else $error("register access not answered after one wait");
    AST_RD_UPPER: assert property (avs_readdata[31:24] == 8'h00)
        else $error("upper read data not zero");
    AST_TRAIL_RD: assert property ($rose(extRdN) |-> ##[0:2] accDone)
        else $error("read end not within two trailing waits");
    AST_TRAIL_WR: assert property ($rose(extWrN) |-> ##[0:2] accDone)
        else $error("write end not within two trailing waits");
    AST_WR_OE: assert property (!extWrN |-> extDataOe)
        else $error("write strobe without driven data");
    AST_DRAM_QUIET: assert property (dramReq |-> extRdN && extWrN)
        else $error("SRAM strobe during a DRAM access");
endmodule : ebw_bus_ctrl_monitor

bind ebw_bus_ctrl ebw_bus_ctrl_monitor uMon (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .accReq(accReq),
    .accDone(accDone), .busReqOut(busReqOut), .busGrant(busGrant), .extDataOe(extDataOe),
    .extRdN(extRdN), .extWrN(extWrN), .dramReq(dramReq));

// File: test/ebw_ext_model.sv
// External SRAM, bus arbiter and DRAM hand-off stand-in
`timescale 1ns/1ns
module ebw_ext_model #(
    parameter int GRANT_DLY = 3
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        busReqOut,
    output logic            busGrant,
    input wire logic [23:0] extAddr,
    input wire logic [23:0] extDataOut,
    input wire logic        extDataOe,
    output logic     [23:0] extDataIn,
    input wire logic        extRdN,
    input wire logic        extWrN,
    input wire logic        dramReq,
    output logic            dramDone
);
    logic [23:0] mem [0:255];
    logic [23:0] lastQ;
    logic [7:0]  idx;
    logic [3:0]  grantSr;
    logic [2:0]  dramCnt;

    // Grant comes late and leaves with the request; released data is the inverse of the last
    assign idx       = {extAddr[23:20], extAddr[3:0]};
    assign busGrant  = busReqOut && grantSr[GRANT_DLY-1];
    assign extDataIn = !extRdN ? mem[idx] : ~lastQ;
    assign dramDone  = (dramCnt == 3'h3);

    // Memory store, arbiter delay line and DRAM completion timer
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            grantSr <= 4'h0;
            lastQ   <= 24'h00_0000;
            dramCnt <= 3'h0;
        end else begin
            grantSr <= busReqOut ? {grantSr[2:0], 1'b1} : 4'h0;
            dramCnt <= (dramReq && !dramDone) ? dramCnt + 3'h1 : 3'h0;
            if (!extRdN) lastQ <= mem[idx];
            if (!extWrN && extDataOe) mem[idx] <= extDataOut;
        end
    end
endmodule : ebw_ext_model

// File: test/external_bus_wait_state_control_test.sv
// Self-checking bench of the bus wait block with its far side
`timescale 1ns/1ns
module external_bus_wait_state_control_test;
    logic        core_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable;
    logic        accReq, accWrite, accDone, busReqOut, busGrant;
    logic [23:0] accAddr, accWdata, accRdata, extAddr, extDataOut, extDataIn, a;
    logic        extDataOe, extRdN, extWrN, dramReq, dramDone;
    int          errTotal, numChecks, cyc, strb, drm;
    int          ar [11] = '{0, 0, 0, 0, 0, 0, 1, 2, 4, 4, 3};
    int          wt [11] = '{1, 3, 4, 7, 8, 31, 5, 7, 9, 3, 5};

    ebw_bus_ctrl DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .accReq(accReq), .accWrite(accWrite),
        .accAddr(accAddr), .accWdata(accWdata), .accRdata(accRdata), .accDone(accDone),
        .busReqOut(busReqOut), .busGrant(busGrant), .extAddr(extAddr),
        .extDataOut(extDataOut), .extDataOe(extDataOe), .extDataIn(extDataIn),
        .extRdN(extRdN), .extWrN(extWrN), .dramReq(dramReq), .dramDone(dramDone));
    ebw_ext_model uFar (.core_clk(core_clk), .rst(rst), .busReqOut(busReqOut),
        .busGrant(busGrant), .extAddr(extAddr), .extDataOut(extDataOut),
        .extDataOe(extDataOe), .extDataIn(extDataIn), .extRdN(extRdN), .extWrN(extWrN),
        .dramReq(dramReq), .dramDone(dramDone));

    // 125 MHz core clock
    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chkVal

    task automatic chkCnt(input int got, input int exp);
        numChecks++;
        if (got != exp) begin
            errTotal++;
            $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask : chkCnt

    // Avalon access: request held up to the edge that sees waitrequest low, data taken there
    task automatic regAcc(input logic wr, input logic [5:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= ad;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : regAcc

    // Core access held until the done pulse; counts cycles, strobe cycles, DRAM cycles
    task automatic memAcc(input logic wr, input logic [23:0] ad, input logic [23:0] d);
        cyc = 0;
        strb = 0;
        drm = 0;
        @(posedge core_clk);
        accReq   <= 1'b1;
        accWrite <= wr;
        accAddr  <= ad;
        accWdata <= d;
        forever begin
            @(negedge core_clk);
            cyc++;
            if (!extRdN || !extWrN) strb++;
            if (dramReq) drm++;
            if (accDone) break;
        end
        rd = 32'(accRdata);
        @(posedge core_clk);
        accReq <= 1'b0;
    endtask : memAcc

    function automatic int trail(input int w);
        return (w >= 8) ? 2 : ((w >= 4) ? 1 : 0);
    endfunction : trail

    // Hold set, one field replaced; no field is ever zero
    function automatic logic [31:0] mkCtrl(input int ar, input int w);
        logic [4:0] f [5];
        f = '{5'h0c, 5'h09, 5'h06, 5'h03, 5'h02};
        f[ar] = 5'(w);
        return {8'h00, 1'b1, 2'b00, f[4], f[3][2:0], f[2][2:0], f[1], f[0]};
    endfunction : mkCtrl

    task automatic reportAndStop();
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : reportAndStop

    // Watchdog sized well above the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge core_clk);
        errTotal++;
        $display("[ERR] %0t watchdog expired", $time);
        reportAndStop();
    end

    initial begin
        {avs_read, avs_write, accReq, accWrite} = 4'h0;
        {avs_address, avs_writedata, accAddr, accWdata} = '0;
        avs_byteenable = 4'hf;
        rst = 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        regAcc(0, 6'h00, 0);
        chkVal(rd, 32'h001f_ffff);
        regAcc(0, 6'h3c, 0);
        chkVal(rd, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            regAcc(1, 6'(4 + 4 * i),
                   {8'h00, 4'(i + 1), 4'h0, 8'hff, 6'h00, 1'(i == 3), 1'b1});
        end
        regAcc(0, 6'h10, 0);
        chkVal(rd, 32'h0040_ff03);
        // Hold clear: request only around an access, owner bit ignores the write
        regAcc(1, 6'h00, 32'h0020_0000 | (mkCtrl(1, 5) & 32'h007f_ffff));
        @(negedge core_clk) chkVal(32'(busReqOut), 32'h0000_0000);
        memAcc(1, 24'h20_0006, 24'h12_3456);
        memAcc(0, 24'h20_0006, 24'h00_0000);
        chkVal(rd, 32'h0012_3456);
        regAcc(0, 6'h00, 0);
        chkVal(rd, mkCtrl(1, 5) & 32'h007f_ffff);
        // Hold set with reserved bit: request stays up, owner bit follows the grant
        regAcc(1, 6'h00, mkCtrl(1, 5) | 32'h0040_0000);
        repeat (6) @(posedge core_clk);
        @(negedge core_clk) chkVal(32'(busReqOut), 32'h0000_0001);
        regAcc(0, 6'h00, 0);
        chkVal(rd, mkCtrl(1, 5) | 32'h0060_0000);
        // Every area and the default; area 0 with short, middle and long wait counts, area 3 as DRAM
        for (int i = 0; i < 11; i++) begin
            a = (ar[i] == 4) ? 24'h80_0003 : {4'(ar[i] + 1), 16'h0000, 4'(ar[i] + 5)};
            regAcc(1, 6'h00, mkCtrl(ar[i], wt[i]));
            memAcc(1, a, 24'ha5_0000 + 24'(i));
            if (ar[i] != 3) chkCnt(strb, wt[i]);
            memAcc(0, a, 24'h00_0000);
            if (ar[i] == 3) begin
                chkCnt(strb, 0);
                chkCnt(32'(drm > 0), 1);
            end else begin
                chkCnt(cyc, wt[i] + trail(wt[i]) + 3);
                chkVal(rd, 32'(24'ha5_0000 + 24'(i)));
                chkCnt(drm, 0);
            end
        end
        // Second reset in mid-run restores the control reset value
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        regAcc(0, 6'h00, 0);
        chkVal(rd, 32'h001f_ffff);
        reportAndStop();
    end
endmodule : external_bus_wait_state_control_test
